// File: bench/isp_programmer.sv
// Behavioural in-system programmer driving the serial link.
`timescale 1ns/10ps
`default_nettype none
module isp_programmer import isp_pkg::*; #(
  parameter realtime HALF_NS = 24.0,
  parameter realtime START_NS = 2000.0
) (
  input wire logic clk_sys, // Bench clock, phase only
  output logic rst_pin_n, // Device reset pin
  output logic sck, // Serial clock
  output logic mosi, // Serial data out
  input wire logic miso_line // Serial data in
);
  // Pin and clock low from power-up
  initial begin
    rst_pin_n = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic settle();
    #(START_NS);
  endtask
  task automatic set_pin(input logic v);
    @(posedge clk_sys);
    #1.3 rst_pin_n = v;
  endtask
  // Mode 0, MSB first; offset keeps edges clear of the bench clock
  task automatic xfer(input instr_t cmd, output instr_t rsp);
    @(posedge clk_sys);
    #1.3;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #(HALF_NS) sck = 1'b1;
      #(HALF_NS) rsp[i] = miso_line;
      sck = 1'b0;
    end
    mosi = ~mosi; // Released line shows no stale bit
  endtask
  // Poll until the pending flag clears; the bench watchdog bounds it
  task automatic poll(output logic [7:0] first);
    instr_t r;
    xfer(32'hF000_0000, r);
    first = r.b4;
    while (r.b4[0] !== 1'b0) xfer(32'hF000_0000, r);
  endtask
endmodule
`default_nettype wire

// File: bench/serial_prog_port_properties.sv
// Concurrent checks on the serial programming port pins and bus.
`timescale 1ns/10ps
`default_nettype none
module serial_prog_port_properties (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic rst_pin_n, // Reset pin
  input wire logic sck, // Serial clock
  input wire logic mosi, // Serial in
  input wire logic miso, // Serial out
  input wire logic miso_oe, // Serial out on
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp // Response
);
  logic sck_q, miso_q;
  logic [4:0] nbit;
  logic [8:0] hist;
  logic [3:0] since_fall;
  logic [1:0] flips;
  wire logic rise = sck && !sck_q;
  wire logic fall = !sck && sck_q;
  wire logic rd_phase = hsel && htrans[1] && hready && !hwrite;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Edge finder and bit count; an idle port restarts the count
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sck_q <= 1'b0;
      nbit <= 5'h00;
      hist <= 9'h000;
    end else begin
      sck_q <= sck;
      if (!miso_oe) nbit <= 5'h00;
      else if (rise) nbit <= nbit + 5'h01;
      if (rise) hist <= {hist[7:0], mosi};
    end
  end
  // Distance from last fall; flips counted so a double shift shows
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      miso_q <= 1'b0;
      since_fall <= 4'h0;
      flips <= 2'h0;
    end else begin
      miso_q <= miso;
      since_fall <= fall ? 4'h0 : since_fall + 4'(since_fall != 4'hF);
      flips <= fall ? 2'h0 : flips + 2'(miso_oe && miso != miso_q && flips != 2'h3);
    end
  end
  property p_pin_idle;
    rst_pin_n [*6] |-> !miso_oe;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("out enabled, pin high");
  property p_fall_only;
    miso_oe && $past(miso_oe) && miso != $past(miso) |-> since_fall <= 4'h6;
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("out moved off fall");
  property p_one_flip;
    flips <= 2'h1;
  endproperty
  a_one_flip: assert property (p_one_flip) else $error("two bits in one period");
  property p_echo;
    fall && miso_oe && nbit >= 5'h09 && nbit <= 5'h18 |-> miso == hist[8];
  endproperty
  a_echo: assert property (p_echo) else $error("echo bit wrong");
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_unmapped;
    rd_phase && haddr[7:0] > 8'h0C |=> hrdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    !rd_phase |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind serial_prog_port serial_prog_port_properties u_props (
  .clk_sys, .reset, .rst_pin_n, .sck, .mosi, .miso, .miso_oe, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp);
`default_nettype wire

// File: bench/serial_prog_port_test.sv
// Self-checking bench for the serial programming port.
`timescale 1ns/10ps
`default_nettype none
module serial_prog_port_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic miso, miso_oe, rst_pin_n, sck, mosi, hreadyout, hresp, miso_line;
  wire logic [31:0] hrdata;
  int fail_count = 0;
  int num_checks = 0;
  logic [31:0] w, r;
  logic [7:0] b;
  assign miso_line = miso_oe ? miso : ~miso; // Undriven line shows no stale bit
  always #2.5 clk_sys = ~clk_sys;
  serial_prog_port #(.PAGE_WAIT_CYC(200), .EE_WAIT_CYC(100), .ERASE_WAIT_CYC(9000)) dut (
    .clk_sys, .reset, .rst_pin_n, .sck, .mosi, .miso, .miso_oe, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
  isp_programmer prog (.clk_sys, .rst_pin_n, .sck, .mosi, .miso_line);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic [7:0] got, input logic [7:0] exp);
    check(32'(got), 32'(exp));
  endtask
  // Single word transfer; each phase waits on ready
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    w = hrdata;
  endtask
  task automatic sp(input logic [31:0] c);
    prog.xfer(c, r);
  endtask
  task automatic rd(input logic [31:0] c, input logic [7:0] e);
    sp(c);
    chkb(r[7:0], e);
  endtask
  // Writes to read-only and unmapped places first, then reset values
  task automatic t_regs();
    logic [31:0] exp [5] = '{32'h0000_0001, 32'h0000_000C, 32'h0000_0080,
      32'hFFFF_DF62, 32'h0000_0000};
    ahb(1'b1, 8'h04, 32'hFFFF_FFFF);
    ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, 8'(4 * i), 32'h0000_0000);
      check(w, exp[i]);
    end
    ahb(1'b1, 8'h08, 32'h0000_0047);
  endtask
  // Erase refused and reads only echo before enabling
  task automatic t_locked();
    sp(32'hAC80_0000);
    ahb(1'b0, 8'h04, 32'h0000_0000);
    check(w, 32'h0000_000C);
    sp(32'h2011_3700);
    check({8'h00, r[23:0]}, 32'h0020_1137);
  endtask
  task automatic t_enable();
    sp(32'hAC53_0000);
    chkb(r[15:8], 8'h53);
    ahb(1'b0, 8'h04, 32'h0000_0000);
    check(w, 32'h0000_000E);
  endtask
  task automatic t_erase();
    sp(32'hAC80_0000);
    prog.poll(b);
    chkb(8'(b[0]), 8'h01);
    rd(32'h2000_1200, 8'hFF);
    rd(32'h2800_1200, 8'hFF);
    rd(32'hA000_0500, 8'hFF);
  endtask
  // Two words out of order into page one
  task automatic t_flash();
    sp(32'h4D00_0000);
    sp(32'h4000_0311);
    sp(32'h4800_0322);
    sp(32'h4000_0133);
    sp(32'h4800_0144);
    sp(32'h4C00_4000);
    prog.poll(b);
    rd(32'h2000_4300, 8'h11);
    rd(32'h2800_4300, 8'h22);
    rd(32'h2000_4100, 8'h33);
    rd(32'h2800_4100, 8'h44);
    rd(32'h2000_4200, 8'hFF);
  endtask
  task automatic t_eeprom();
    sp(32'hC000_070F);
    prog.poll(b);
    sp(32'hC000_07F0);
    prog.poll(b);
    rd(32'hA000_0700, 8'hF0);
    sp(32'hC100_01AB);
    sp(32'hC200_0400);
    prog.poll(b);
    rd(32'hA000_0500, 8'hAB);
    rd(32'hA000_0700, 8'hF0);
    rd(32'hA000_0400, 8'hFF);
  endtask
  // Each fuse and lock byte written then read back
  task automatic t_fuses();
    logic [31:0] t [4] = '{32'hA0E1_5000, 32'hA8D9_5808, 32'hA4FD_5008, 32'hE0FC_5800};
    logic [7:0] sigs [3] = '{8'h5A, 8'h3C, 8'h0F};
    for (int i = 0; i < 4; i++) begin
      sp({8'hAC, t[i][31:24], 8'h00, t[i][23:16]});
      prog.poll(b);
      rd({t[i][15:0], 16'h0000}, t[i][23:16]);
    end
    ahb(1'b0, 8'h0C, 32'h0000_0000);
    check(w, 32'hFCFD_D9E1);
    for (int i = 0; i < 3; i++) rd({16'h3000, 8'(i), 8'h00}, sigs[i]);
    rd(32'h3800_0000, 8'h47);
  endtask
  // Port shut by control bit, then by the pin; re-enable after
  task automatic t_inactive();
    ahb(1'b1, 8'h00, 32'h0000_0000);
    repeat (8) @(posedge clk_sys);
    check(32'(miso_oe), 32'h0000_0000);
    ahb(1'b1, 8'h00, 32'h0000_0001);
    prog.set_pin(1'b1);
    repeat (8) @(posedge clk_sys);
    check(32'(miso_oe), 32'h0000_0000);
    ahb(1'b0, 8'h04, 32'h0000_0000);
    check(w & 32'h0000_000C, 32'h0000_0000);
    prog.set_pin(1'b0);
    repeat (8) @(posedge clk_sys);
    sp(32'hAC53_0000);
    chkb(r[15:8], 8'h53);
    rd(32'h2000_4300, 8'h11);
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    prog.settle();
    t_regs();
    t_locked();
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_fuses();
    t_inactive();
    give_verdict();
  end
endmodule
`default_nettype wire

// File: rtl/isp_cfg.svh
// Constants of the serial programming port: opcodes, offsets, timings, resets.
// Function
// RQ1 - Port works only while reset pin low
// RQ2 - Enable instruction required before program or erase
// RQ3 - EEPROM byte write erases location itself
// RQ4 - Chip erase sets flash and EEPROM to ones
// RQ5 - Programmer keeps SCK phases over two/three clocks
// RQ6 - MOSI sampled on rise, MISO shifted on fall
// RQ7 - Programmer holds reset and SCK low at power-up
// RQ8 - Programmer waits 20 ms before enabling; the bench programmer waits 2000 ns
// RQ9 - Second enable byte echoes during third byte
// RQ10 - Flash page buffer loaded bytewise, 6 address bits
// RQ11 - Programmer loads low byte before high byte
// RQ12 - Page commit with 7 upper bits, 4.5 ms
// RQ13 - EEPROM byte write, next after 3.6 ms
// RQ14 - EEPROM page commit alters only loaded bytes
// RQ15 - Read returns data during fourth byte
// RQ16 - Poll returns pending flag in bit zero
// RQ17 - Four-byte instructions; load opcodes 48 40 C1 4D
// RQ18 - Read opcodes 28 20 A0 with addresses
// RQ19 - Lock, fuse, signature, calibration read codes
// RQ20 - Write opcodes 4C C0 C2 with address
// RQ21 - Lock/fuse writes AC E0 A0 A8 A4
// RQ22 - Program memory uses word addresses, any order
// RQ23 - Bytes shifted MSB first, one bit per period
`ifndef ISP_CFG_SVH
`define ISP_CFG_SVH
`define OP_ENABLE 8'hAC
`define OP_EN_KEY 8'h53
`define OP_ERASE_KEY 8'h80
`define OP_POLL 8'hF0
`define OP_LD_EXT 8'h4D
`define OP_LD_HIGH 8'h48
`define OP_LD_LOW 8'h40
`define OP_LD_EE 8'hC1
`define OP_RD_HIGH 8'h28
`define OP_RD_LOW 8'h20
`define OP_RD_EE 8'hA0
`define OP_RD_LOCK 8'h58
`define OP_RD_FUSE 8'h50
`define OP_RD_SIG 8'h30
`define OP_RD_CAL 8'h38
`define OP_WR_PAGE 8'h4C
`define OP_WR_EE 8'hC0
`define OP_WR_EE_PAGE 8'hC2
`define SUB_LOCK 8'hE0
`define SUB_FUSE_LO 8'hA0
`define SUB_FUSE_HI 8'hA8
`define SUB_FUSE_EXT 8'hA4
`define HIGH_SEL_BIT 3
`define ERASED_BYTE 8'hFF
`define ERASED_WORD 16'hFFFF
`define CLK_MHZ 200
`define PAGE_WAIT_US 4500
`define EE_WAIT_US 3600
`define ERASE_WAIT_US 9000
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CALIB 8'h08
`define REG_FUSES 8'h0C
`define CTRL_RST 1'b1
`define CALIB_RST 8'h80
`define FUSE_LO_RST 8'h62
`define FUSE_HI_RST 8'hDF
`define FUSE_EXT_RST 8'hFF
`define LOCK_RST 8'hFF
`endif

// File: rtl/isp_pkg.sv
// Types shared by the serial programming port modules.
package isp_pkg;
  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } instr_t;
  typedef enum {SWEEP_NONE, SWEEP_ERASE, SWEEP_FPAGE, SWEEP_EPAGE} sweep_t;
  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] ext;
    logic [7:0] high;
    logic [7:0] low;
  } fuses_t;
endpackage

// File: rtl/pin_sync.sv
// Three-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, high
  input wire logic [W-1:0] d, // Raw pins
  output logic [W-1:0] q // Filtered levels
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // Stage one feeds only stage two; a change counts once two and three agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        s1[i] <= INIT[i];
        s2[i] <= INIT[i];
        s3[i] <= INIT[i];
        q[i] <= INIT[i];
      end else begin
        s1[i] <= d[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/serial_prog_port.sv
// Serial in-system programming port with flash, EEPROM, fuses and AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "isp_cfg.svh"
module serial_prog_port import isp_pkg::*; #(
  parameter int FLASH_AW = 13,
  parameter int PAGE_AW = 6,
  parameter int EE_AW = 10,
  parameter int EE_PAGE_AW = 2,
  parameter int unsigned PAGE_WAIT_CYC = `PAGE_WAIT_US * `CLK_MHZ,
  parameter int unsigned EE_WAIT_CYC = `EE_WAIT_US * `CLK_MHZ,
  parameter int unsigned ERASE_WAIT_CYC = `ERASE_WAIT_US * `CLK_MHZ,
  parameter logic [7:0] SIG0 = 8'h5A, // Arbitrary value
  parameter logic [7:0] SIG1 = 8'h3C, // Arbitrary value
  parameter logic [7:0] SIG2 = 8'h0F // Arbitrary value
) (
  input wire logic clk_sys, // System clock, 200 MHz
  input wire logic reset, // Async reset, high
  input wire logic rst_pin_n, // Device reset pin, low = program
  input wire logic sck, // Serial clock pin
  input wire logic mosi, // Serial data in pin
  output logic miso, // Serial data out pin
  output logic miso_oe, // MISO driven
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp // AHB response
);
  localparam int FW = 2 ** FLASH_AW;
  localparam int EW = 2 ** EE_AW;
  localparam int PW = 2 ** PAGE_AW;
  localparam int EPW = 2 ** EE_PAGE_AW;

  logic rst_pin_s_n;
  logic sck_s;
  logic mosi_s;
  logic port_allow;
  logic [7:0] calib;
  logic byte_done;
  logic [1:0] byte_idx;
  logic [7:0] rx_byte;
  logic tx_load;
  logic [7:0] tx_byte;
  logic [7:0] rd_data;
  logic prog_en;
  instr_t ins;
  instr_t full;
  fuses_t fuses;
  logic [7:0] ext_addr;
  sweep_t sweep;
  logic [FLASH_AW-1:0] ptr;
  logic [FLASH_AW-1:0] sweep_last;
  logic [FLASH_AW-PAGE_AW-1:0] fpage;
  logic [EE_AW-EE_PAGE_AW-1:0] epage;
  logic [31:0] wait_cnt;
  logic busy;
  logic exec;
  logic start_erase;
  logic start_fpage;
  logic start_epage;
  logic ee_byte_wr;
  logic fuse_wr;
  logic [15:0] flash [FW];
  logic [7:0] eeprom [EW];
  logic [15:0] fbuf [PW];
  logic [7:0] ebuf [EPW];
  logic [EPW-1:0] eloaded;
  logic [FLASH_AW-1:0] rd_waddr;
  logic [EE_AW-1:0] rd_eaddr;
  logic [FLASH_AW-1:0] wr_waddr;
  logic [EE_AW-1:0] wr_eaddr;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic port_act;

  // Reset pin idles high so the port starts inactive
  pin_sync #(.W(3), .INIT(3'b100)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .d({rst_pin_n, sck, mosi}),
    .q({rst_pin_s_n, sck_s, mosi_s})
  );

  assign port_act = ~rst_pin_s_n & port_allow; // RQ1

  spi_shift u_shift (
    .clk_sys(clk_sys),
    .reset(reset),
    .clear(~port_act),
    .sck_s(sck_s),
    .mosi_s(mosi_s),
    .tx_load(tx_load),
    .tx_byte(tx_byte),
    .byte_done(byte_done),
    .byte_idx(byte_idx),
    .rx_byte(rx_byte),
    .miso(miso)
  );

  // MISO is driven only while the port is in use
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= port_act; // RQ1
    end
  end

  // Collect the four bytes of the instruction
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ins <= '0;
    end else if (byte_done) begin
      unique case (byte_idx)
        2'd0: ins.b1 <= rx_byte;
        2'd1: ins.b2 <= rx_byte;
        2'd2: ins.b3 <= rx_byte;
        2'd3: ins.b4 <= rx_byte;
      endcase
    end
  end

  assign full = '{b1: ins.b1, b2: ins.b2, b3: ins.b3, b4: rx_byte};
  assign exec = byte_done & (byte_idx == 2'd3);
  assign busy = (wait_cnt != 32'h0000_0000) | (sweep != SWEEP_NONE);
  // Word address from the second and third bytes
  assign rd_waddr = FLASH_AW'({ins.b2, rx_byte}); // RQ22
  assign rd_eaddr = EE_AW'({ins.b2, rx_byte});
  assign wr_waddr = FLASH_AW'({full.b2, full.b3});
  assign wr_eaddr = EE_AW'({full.b2, full.b3});

  // Reply for the fourth byte, chosen as the third byte arrives
  always_comb begin
    rd_data = 8'h00;
    unique case (ins.b1)
      `OP_POLL: rd_data = {7'h00, busy}; // RQ16
      `OP_RD_HIGH: rd_data = flash[rd_waddr][15:8]; // RQ18
      `OP_RD_LOW: rd_data = flash[rd_waddr][7:0]; // RQ18
      `OP_RD_EE: rd_data = eeprom[rd_eaddr]; // RQ18
      `OP_RD_LOCK: rd_data = ins.b2[`HIGH_SEL_BIT] ? fuses.high : fuses.lock; // RQ19
      `OP_RD_FUSE: rd_data = ins.b2[`HIGH_SEL_BIT] ? fuses.ext : fuses.low; // RQ19
      `OP_RD_CAL: rd_data = calib; // RQ19
      `OP_RD_SIG: begin
        unique case (rx_byte[1:0])
          2'd0: rd_data = SIG0;
          2'd1: rd_data = SIG1;
          default: rd_data = SIG2;
        endcase
      end
      default: rd_data = rx_byte;
    endcase
  end

  // Echo each byte one byte later; once enabled, reads replace the echo in byte four
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_load <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      tx_load <= byte_done;
      if (byte_done) begin
        if (byte_idx == 2'd2 && prog_en) begin
          tx_byte <= rd_data; // RQ15
        end else begin
          tx_byte <= rx_byte; // RQ9
        end
      end
    end
  end

  // Enable is latched per reset-low session and lost when the pin rises
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prog_en <= 1'b0;
    end else if (!port_act) begin
      prog_en <= 1'b0; // RQ2
    end else if (exec && full.b1 == `OP_ENABLE && full.b2 == `OP_EN_KEY) begin
      prog_en <= 1'b1; // RQ2
    end
  end

  // Decoded commands; nothing starts while disabled or still pending
  always_comb begin
    start_erase = 1'b0;
    start_fpage = 1'b0;
    start_epage = 1'b0;
    ee_byte_wr = 1'b0;
    fuse_wr = 1'b0;
    if (exec && prog_en && !busy) begin // RQ2
      unique case (full.b1)
        `OP_ENABLE: begin
          start_erase = (full.b2 == `OP_ERASE_KEY); // RQ4
          fuse_wr = (full.b2 == `SUB_LOCK) || (full.b2 == `SUB_FUSE_LO) ||
                    (full.b2 == `SUB_FUSE_HI) || (full.b2 == `SUB_FUSE_EXT); // RQ21
        end
        `OP_WR_PAGE: start_fpage = 1'b1; // RQ20
        `OP_WR_EE: ee_byte_wr = 1'b1; // RQ20
        `OP_WR_EE_PAGE: start_epage = 1'b1; // RQ20
        default: ;
      endcase
    end
  end

  // Lock and fuse bytes, zero meaning programmed
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      fuses <= '{lock: `LOCK_RST, ext: `FUSE_EXT_RST, high: `FUSE_HI_RST, low: `FUSE_LO_RST};
    end else if (start_erase) begin
      fuses.lock <= `ERASED_BYTE; // Lock bits clear only by erase
    end else if (fuse_wr) begin
      unique case (full.b2)
        `SUB_LOCK: fuses.lock <= fuses.lock & full.b4; // RQ21
        `SUB_FUSE_LO: fuses.low <= full.b4; // RQ21
        `SUB_FUSE_HI: fuses.high <= full.b4; // RQ21
        default: fuses.ext <= full.b4; // RQ21
      endcase
    end
  end

  // Extended address is held but unused at this array size
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ext_addr <= 8'h00;
    end else if (exec && prog_en && full.b1 == `OP_LD_EXT) begin
      ext_addr <= full.b3; // RQ17
    end
  end

  // Flash page buffer, refilled with ones after each commit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < PW; i++) fbuf[i] <= `ERASED_WORD;
    end else if (sweep == SWEEP_FPAGE && ptr == sweep_last) begin
      for (int i = 0; i < PW; i++) fbuf[i] <= `ERASED_WORD;
    end else if (exec && prog_en && full.b1 == `OP_LD_LOW) begin
      fbuf[full.b3[PAGE_AW-1:0]][7:0] <= full.b4; // RQ10
    end else if (exec && prog_en && full.b1 == `OP_LD_HIGH) begin
      fbuf[full.b3[PAGE_AW-1:0]][15:8] <= full.b4; // RQ10
    end
  end

  // EEPROM page buffer with a loaded mark per byte; a load beats the commit's clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < EPW; i++) ebuf[i] <= `ERASED_BYTE;
      eloaded <= '0;
    end else begin
      if (sweep == SWEEP_EPAGE && ptr == sweep_last) eloaded <= '0;
      if (exec && prog_en && full.b1 == `OP_LD_EE) begin
        ebuf[full.b3[EE_PAGE_AW-1:0]] <= full.b4; // RQ17
        eloaded[full.b3[EE_PAGE_AW-1:0]] <= 1'b1; // RQ14
      end
    end
  end

  // Sweep engine walks one location per cycle for erase and page commits
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sweep <= SWEEP_NONE;
      ptr <= '0;
      sweep_last <= '0;
      fpage <= '0;
      epage <= '0;
    end else if (sweep != SWEEP_NONE) begin
      ptr <= ptr + 1'b1;
      if (ptr == sweep_last) sweep <= SWEEP_NONE;
    end else if (start_erase) begin
      sweep <= SWEEP_ERASE; // RQ4
      ptr <= '0;
      sweep_last <= FLASH_AW'(FW - 1);
    end else if (start_fpage) begin
      sweep <= SWEEP_FPAGE; // RQ12
      ptr <= '0;
      sweep_last <= FLASH_AW'(PW - 1);
      fpage <= wr_waddr[FLASH_AW-1:PAGE_AW]; // RQ12
    end else if (start_epage) begin
      sweep <= SWEEP_EPAGE;
      ptr <= '0;
      sweep_last <= FLASH_AW'(EPW - 1);
      epage <= wr_eaddr[EE_AW-1:EE_PAGE_AW];
    end
  end

  // Self-timed wait; the sweep is far shorter than any wait
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_cnt <= 32'h0000_0000;
    end else if (start_erase) begin
      wait_cnt <= ERASE_WAIT_CYC;
    end else if (start_fpage) begin
      wait_cnt <= PAGE_WAIT_CYC; // RQ12
    end else if (start_epage || ee_byte_wr || fuse_wr) begin
      wait_cnt <= EE_WAIT_CYC; // RQ13
    end else if (wait_cnt != 32'h0000_0000) begin
      wait_cnt <= wait_cnt - 32'h0000_0001;
    end
  end

  // Flash array, one write port shared by erase and page commit
  always_ff @(posedge clk_sys) begin
    if (sweep == SWEEP_ERASE) begin
      flash[ptr] <= `ERASED_WORD; // RQ4
    end else if (sweep == SWEEP_FPAGE) begin
      flash[{fpage, ptr[PAGE_AW-1:0]}] <= fbuf[ptr[PAGE_AW-1:0]]; // RQ12
    end
  end

  // EEPROM array; a byte write overwrites whole, so no erase is needed first
  always_ff @(posedge clk_sys) begin
    if (sweep == SWEEP_ERASE && ptr < FLASH_AW'(EW)) begin
      eeprom[ptr[EE_AW-1:0]] <= `ERASED_BYTE; // RQ4
    end else if (sweep == SWEEP_EPAGE && eloaded[ptr[EE_PAGE_AW-1:0]]) begin
      eeprom[{epage, ptr[EE_PAGE_AW-1:0]}] <= ebuf[ptr[EE_PAGE_AW-1:0]]; // RQ14
    end else if (ee_byte_wr) begin
      eeprom[wr_eaddr] <= full.b4; // RQ3 RQ13
    end
  end

  // AHB address phase capture; writes land in the data phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel & htrans[1] & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Software registers: port gate and calibration byte
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_allow <= `CTRL_RST;
      calib <= `CALIB_RST;
    end else if (wr_pend) begin
      if (wr_addr == `REG_CTRL) port_allow <= hwdata[0];
      if (wr_addr == `REG_CALIB) calib <= hwdata[7:0];
    end
  end

  // Read data is prepared in the address phase; unmapped words read zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        `REG_CTRL: hrdata <= {31'h0000_0000, port_allow};
        `REG_STATUS: hrdata <= {28'h000_0000, port_act, ~rst_pin_s_n, prog_en, busy};
        `REG_CALIB: hrdata <= {24'h00_0000, calib};
        `REG_FUSES: hrdata <= fuses;
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero wait states, always OKAY; hsize is accepted but only words are meaningful
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: rtl/spi_shift.sv
// Serial byte engine: samples MOSI on SCK rise, drives MISO on SCK fall.
`timescale 1ns/10ps
`default_nettype none
module spi_shift (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Async reset, high
  input wire logic clear, // Hold engine idle
  input wire logic sck_s, // Synchronised SCK
  input wire logic mosi_s, // Synchronised MOSI
  input wire logic tx_load, // Load next reply byte
  input wire logic [7:0] tx_byte, // Next reply byte
  output logic byte_done, // Pulse: byte received
  output logic [1:0] byte_idx, // Index of that byte
  output logic [7:0] rx_byte, // Received byte
  output logic miso // Serial data out
);
  logic sck_d;
  logic [2:0] bit_cnt;
  logic [1:0] idx;
  logic [6:0] rx_sr;
  logic [7:0] tx_sr;
  wire rise = sck_s & ~sck_d;
  wire fall = ~sck_s & sck_d;

  // Edge history of the filtered clock
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  // Receive side, MSB first, one bit per rising edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bit_cnt <= 3'h0;
      idx <= 2'h0;
      rx_sr <= 7'h00;
      byte_done <= 1'b0;
      byte_idx <= 2'h0;
      rx_byte <= 8'h00;
    end else if (clear) begin
      bit_cnt <= 3'h0;
      idx <= 2'h0;
      byte_done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (rise) begin // RQ6
        rx_sr <= {rx_sr[5:0], mosi_s}; // RQ23
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          rx_byte <= {rx_sr, mosi_s};
          byte_done <= 1'b1;
          byte_idx <= idx;
          idx <= idx + 2'h1; // RQ17
        end
      end
    end
  end

  // Transmit side; the load lands before the next falling edge
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_sr <= 8'h00;
      miso <= 1'b0;
    end else if (clear) begin
      tx_sr <= 8'h00;
      miso <= 1'b0;
    end else if (tx_load) begin
      tx_sr <= tx_byte;
    end else if (fall) begin // RQ6
      miso <= tx_sr[7]; // RQ23
      tx_sr <= {tx_sr[6:0], 1'b0};
    end
  end
endmodule
`default_nettype wire
